// >>> src/plfe_top.sv
// Purpose: LED function engine with AXI4-Lite register access
// Assumes: event_in comes from logic on aclk; LEDs light on a high output
// Notes: all LEDs share one pair of blink generators
// Operation
// - up to four LED outputs, high lights the LED
// - each LED runs internally or externally controlled
// - external mode drives the LED from a writable register bit
// - external mode off after reset; clearing the enable bit selects it
// - direct bit one lights, zero darkens, in external mode
// - several activities per LED resolved by fixed priority
// - any active complex function beats every direct function
// - direct order: pulse, fast blink, slow blink, constant on, none
// - each new event gives one on-off pulse; events during it ignored
// - pulse phases last one fast-blink half period
// - fast blink toggles at the global fast rate
// - slow blink toggles at the global slow rate
// - constant on holds the LED lit from its selected trigger
// - no direct function leaves the LED dark
// - synced blink at fast rate, even LEDs opposite to odd ones
// - walk one lit LED up and back, stepping at fast rate
// - inverted walk is the walk with every output inverted
// - complex order: synced blink, walk, inverted walk, none
// - two global fields set the fast and slow rates
// - each LED has one event selection per direct function
`timescale 1ns/100ps
`include "plfe_cfg.svh"
module plfe_top
	import plfe_pkg::*;
#(
	parameter int NUM_LEDS = 4,
	parameter int NUM_EVENTS = 7,
	parameter int TICK_CYCLES = `PLFE_TICK_CYCLES
) (
	input wire logic aclk, // core clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic [2:0] s_axi_awprot, // unused
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic [2:0] s_axi_arprot, // unused
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [NUM_EVENTS-1:0] event_in, // status/event levels from the PHY
	output logic [NUM_LEDS-1:0] led_out // LED pins, high lights
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	generate
		if (NUM_LEDS < 2 || NUM_LEDS > 4) begin : g_bad_leds
			$error("NUM_LEDS must be 2 to 4");
		end
		if (NUM_EVENTS < 1 || NUM_EVENTS > 7) begin : g_bad_events
			$error("NUM_EVENTS must be 1 to 7");
		end
		if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
			$error("TICK_CYCLES must be 1 to 65536");
		end
	endgenerate

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic aw_held;
	logic [7:0] aw_addr;
	logic w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_hit;
	logic [31:0] direct_reg;
	logic [31:0] complex_reg;
	logic [31:0] led_cfg [NUM_LEDS];
	logic [31:0] rd_mux;
	logic rd_hit;
	logic [15:0] tick_cnt;
	logic tick;
	logic [NUM_EVENTS-1:0] event_q;
	logic [NUM_EVENTS-1:0] event_rise;
	logic [1:0] walk_pos;
	logic walk_down;
	logic synced_on;
	logic walk_on;
	logic inv_walk_on;
	logic complex_on;
	logic [NUM_LEDS-1:0] pulse_busy;
	logic [NUM_LEDS-1:0] next_led;

	plfe_rate_if fast_if ();
	plfe_rate_if slow_if ();

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res & mask;
	endfunction

	// a select of zero means none; k picks event k-1
	function automatic logic pick(input logic [2:0] sel, input logic [NUM_EVENTS-1:0] ev);
		logic res;
		res = 1'b0;
		for (int k = 0; k < NUM_EVENTS; k++) begin
			if (sel == 3'(k + 1)) begin
				res = ev[k];
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		wr_hit = 1'b0;
		if (aw_addr[7:2] == `PLFE_ADDR_DIRECT >> 2 || aw_addr[7:2] == `PLFE_ADDR_COMPLEX >> 2) begin
			wr_hit = 1'b1;
		end
		for (int i = 0; i < NUM_LEDS; i++) begin
			if (aw_addr[7:2] == 6'((`PLFE_ADDR_LEDCFG_BASE >> 2) + i)) begin
				wr_hit = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PLFE_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? PLFE_RESP_OKAY : PLFE_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// enables reset to one, so every LED starts internally controlled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			direct_reg <= `PLFE_RST_DIRECT;
		end else if (do_write && aw_addr[7:2] == `PLFE_ADDR_DIRECT >> 2) begin
			direct_reg <= merge(direct_reg, w_data, w_strb, `PLFE_MASK_DIRECT);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			complex_reg <= `PLFE_RST_COMPLEX;
		end else if (do_write && aw_addr[7:2] == `PLFE_ADDR_COMPLEX >> 2) begin
			complex_reg <= merge(complex_reg, w_data, w_strb, `PLFE_MASK_COMPLEX);
		end
	end

	generate
		for (genvar i = 0; i < NUM_LEDS; i++) begin : g_cfg
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					led_cfg[i] <= `PLFE_RST_LEDCFG;
				end else if (do_write &&
					aw_addr[7:2] == 6'((`PLFE_ADDR_LEDCFG_BASE >> 2) + i)) begin
					led_cfg[i] <= merge(led_cfg[i], w_data, w_strb, `PLFE_MASK_LEDCFG);
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b0;
		if (s_axi_araddr[7:2] == `PLFE_ADDR_DIRECT >> 2) begin
			rd_mux = direct_reg;
			rd_hit = 1'b1;
		end
		if (s_axi_araddr[7:2] == `PLFE_ADDR_COMPLEX >> 2) begin
			rd_mux = complex_reg;
			rd_hit = 1'b1;
		end
		if (s_axi_araddr[7:2] == `PLFE_ADDR_STATUS >> 2) begin
			rd_mux[`PLFE_ST_LED_LSB +: NUM_LEDS] = led_out;
			rd_mux[`PLFE_ST_BUSY_LSB +: NUM_LEDS] = pulse_busy;
			rd_mux[`PLFE_ST_POS_LSB +: 2] = walk_pos;
			rd_mux[`PLFE_ST_DIR_BIT] = walk_down;
			rd_hit = 1'b1;
		end
		for (int i = 0; i < NUM_LEDS; i++) begin
			if (s_axi_araddr[7:2] == 6'((`PLFE_ADDR_LEDCFG_BASE >> 2) + i)) begin
				rd_mux = led_cfg[i];
				rd_hit = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= PLFE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_hit ? PLFE_RESP_OKAY : PLFE_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// shared timebase
	// ----------------------------------------
	// one prescaler for both rates keeps all blinks on common edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
			tick_cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	assign fast_if.tick = tick;
	assign slow_if.tick = tick;
	assign fast_if.half_ticks = `PLFE_FAST_UNIT_TICKS *
		({13'h0000, complex_reg[`PLFE_FAST_SEL_LSB +: 3]} + 16'h0001);
	assign slow_if.half_ticks = `PLFE_SLOW_UNIT_TICKS *
		({13'h0000, complex_reg[`PLFE_SLOW_SEL_LSB +: 3]} + 16'h0001);

	plfe_rate_gen u_fast (
		.aclk(aclk),
		.aresetn(aresetn),
		.rate(fast_if.gen)
	);

	plfe_rate_gen u_slow (
		.aclk(aclk),
		.aresetn(aresetn),
		.rate(slow_if.gen)
	);

	// ----------------------------------------
	// complex functions
	// ----------------------------------------
	assign synced_on = complex_reg[`PLFE_SYNCED_BIT];
	assign walk_on = complex_reg[`PLFE_WALK_BIT];
	assign inv_walk_on = complex_reg[`PLFE_INVWALK_BIT];
	assign complex_on = synced_on || walk_on || inv_walk_on;

	// the walk restarts at LED0 whenever neither walk is selected
	always_ff @(posedge aclk) begin
		if (!aresetn || !(walk_on || inv_walk_on)) begin
			walk_pos <= 2'h0;
			walk_down <= 1'b0;
		end else if (fast_if.step) begin
			if (!walk_down) begin
				if (walk_pos == 2'(NUM_LEDS - 1)) begin
					walk_down <= 1'b1;
					walk_pos <= walk_pos - 2'h1;
				end else begin
					walk_pos <= walk_pos + 2'h1;
				end
			end else begin
				if (walk_pos == 2'h0) begin
					walk_down <= 1'b0;
					walk_pos <= 2'h1;
				end else begin
					walk_pos <= walk_pos - 2'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// per-LED direct functions
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_q <= '0;
		end else begin
			event_q <= event_in;
		end
	end

	assign event_rise = event_in & ~event_q;

	generate
		for (genvar i = 0; i < NUM_LEDS; i++) begin : g_led
			plfe_pulse_state_type pstate;
			logic [15:0] ptimer;
			logic pulse_start;
			logic phase_done;
			logic direct_val;
			logic complex_val;

			assign pulse_start = pick(led_cfg[i][`PLFE_PULSE_SEL_LSB +: 3], event_rise);
			assign phase_done = tick && (ptimer + 16'h0001 >= fast_if.half_ticks);

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pstate <= PLFE_P_IDLE;
					ptimer <= 16'h0000;
				end else begin
					case (pstate)
						PLFE_P_IDLE: begin
							ptimer <= 16'h0000;
							if (pulse_start) begin
								pstate <= PLFE_P_ON;
							end
						end
						PLFE_P_ON: begin
							if (phase_done) begin
								ptimer <= 16'h0000;
								pstate <= PLFE_P_OFF;
							end else if (tick) begin
								ptimer <= ptimer + 16'h0001;
							end
						end
						PLFE_P_OFF: begin
							if (phase_done) begin
								ptimer <= 16'h0000;
								pstate <= PLFE_P_IDLE;
							end else if (tick) begin
								ptimer <= ptimer + 16'h0001;
							end
						end
						default: begin
							pstate <= PLFE_P_IDLE;
							ptimer <= 16'h0000;
						end
					endcase
				end
			end

			assign pulse_busy[i] = (pstate != PLFE_P_IDLE);

			// fixed priority multiplexes several activities on one pin
			always_comb begin
				if (pulse_busy[i]) begin
					direct_val = (pstate == PLFE_P_ON);
				end else if (pick(led_cfg[i][`PLFE_FASTF_SEL_LSB +: 3], event_in)) begin
					direct_val = fast_if.phase;
				end else if (pick(led_cfg[i][`PLFE_SLOWF_SEL_LSB +: 3], event_in)) begin
					direct_val = slow_if.phase;
				end else if (pick(led_cfg[i][`PLFE_CONST_SEL_LSB +: 3], event_in)) begin
					direct_val = 1'b1;
				end else begin
					direct_val = 1'b0;
				end
			end

			always_comb begin
				if (synced_on) begin
					complex_val = fast_if.phase ^ ((i % 2) == 0);
				end else if (walk_on) begin
					complex_val = (walk_pos == 2'(i));
				end else begin
					complex_val = (walk_pos != 2'(i));
				end
			end

			always_comb begin
				if (!direct_reg[`PLFE_DIRECT_EN_LSB + i]) begin
					next_led[i] = direct_reg[`PLFE_DIRECT_VAL_LSB + i];
				end else if (complex_on) begin
					next_led[i] = complex_val;
				end else begin
					next_led[i] = direct_val;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// LED pins
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			led_out <= '0;
		end else begin
			led_out <= next_led;
		end
	end

endmodule // plfe_top

// >>> src/plfe_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the LED engine
// Assumes: 32-bit register words on byte addresses, 10 MHz core clock
// Notes: included by its bare name
`ifndef PLFE_CFG_SVH
`define PLFE_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PLFE_ADDR_DIRECT 8'h00
`define PLFE_ADDR_COMPLEX 8'h04
`define PLFE_ADDR_STATUS 8'h08
`define PLFE_ADDR_LEDCFG_BASE 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define PLFE_DIRECT_VAL_LSB 0
`define PLFE_DIRECT_EN_LSB 4
`define PLFE_FAST_SEL_LSB 0
`define PLFE_SLOW_SEL_LSB 4
`define PLFE_SYNCED_BIT 8
`define PLFE_WALK_BIT 9
`define PLFE_INVWALK_BIT 10
`define PLFE_PULSE_SEL_LSB 0
`define PLFE_FASTF_SEL_LSB 4
`define PLFE_SLOWF_SEL_LSB 8
`define PLFE_CONST_SEL_LSB 12
`define PLFE_ST_LED_LSB 0
`define PLFE_ST_BUSY_LSB 4
`define PLFE_ST_POS_LSB 8
`define PLFE_ST_DIR_BIT 10

// ----------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------
`define PLFE_RST_DIRECT 32'h0000_00F0
`define PLFE_RST_COMPLEX 32'h0000_0000
`define PLFE_RST_LEDCFG 32'h0000_0000
`define PLFE_MASK_DIRECT 32'h0000_00FF
`define PLFE_MASK_COMPLEX 32'h0000_0777
`define PLFE_MASK_LEDCFG 32'h0000_7777

// ----------------------------------------
// timing
// ----------------------------------------
`define PLFE_CLK_NS 100
`define PLFE_TICK_NS 1000000
`define PLFE_TICK_CYCLES ((`PLFE_TICK_NS + `PLFE_CLK_NS - 1) / `PLFE_CLK_NS)
`define PLFE_FAST_UNIT_TICKS 16'h0019
`define PLFE_SLOW_UNIT_TICKS 16'h0064

`endif

// >>> src/plfe_pkg.sv
// Purpose: shared types of the LED engine
// Assumes: nothing beyond the config header
// Notes: pulse states are one-hot
package plfe_pkg;
	typedef enum logic [2:0] {
		PLFE_P_IDLE = 3'b001,
		PLFE_P_ON = 3'b010,
		PLFE_P_OFF = 3'b100
	} plfe_pulse_state_type;

	typedef logic [1:0] plfe_resp_type;
	localparam plfe_resp_type PLFE_RESP_OKAY = 2'h0;
	localparam plfe_resp_type PLFE_RESP_SLVERR = 2'h2;
endpackage

// >>> src/plfe_rate_if.sv
// Purpose: carries one blink rate between the top and a rate generator
// Assumes: tick is a one-cycle strobe on aclk
// Notes: half_ticks is the half period in ticks
`timescale 1ns/100ps
interface plfe_rate_if;
	logic tick;
	logic [15:0] half_ticks;
	logic phase;
	logic step;
	modport gen(input tick, input half_ticks, output phase, output step);
	modport use_side(output tick, output half_ticks, input phase, input step);
endinterface

// >>> src/plfe_rate_gen.sv
// Purpose: free-running blink phase generator for one rate
// Assumes: half_ticks is at least one
// Notes: a shorter new half period takes effect at once because of the >= compare
`timescale 1ns/100ps
module plfe_rate_gen
	import plfe_pkg::*;
(
	input wire logic aclk, // core clock
	input wire logic aresetn, // sync reset, active low
	plfe_rate_if.gen rate // tick in, phase and step out
);
	logic [15:0] cnt;

	// ----------------------------------------
	// half-period counter
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 16'h0000;
			rate.phase <= 1'b0;
			rate.step <= 1'b0;
		end else begin
			rate.step <= 1'b0;
			if (rate.tick) begin
				if (cnt + 16'h0001 >= rate.half_ticks) begin
					cnt <= 16'h0000;
					rate.phase <= ~rate.phase;
					rate.step <= 1'b1;
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end
		end
	end
endmodule // plfe_rate_gen

// >>> bench/plfe_top_monitor.sv
// Purpose: bus handshake and reset checks at the ports of the LED engine
// Assumes: one aclk domain, aresetn synchronous active low
// Notes: bound into every plfe_top instance
`timescale 1ns/100ps
module plfe_top_monitor #(
	parameter int NUM_LEDS = 4
) (
	input wire logic aclk, // core clock
	input wire logic aresetn, // sync reset, active low
	input wire logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	input wire logic s_axi_wvalid, // write data valid
	input wire logic s_axi_wready, // write data ready
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [NUM_LEDS-1:0] led_out // LED pins
);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_reset_dark: assert property (@(posedge aclk)
		!aresetn |=> led_out == '0 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not cleared after reset");
	chk_b_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_aw_held: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second write address accepted");
	chk_r_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	chk_ar_busy: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while busy");
	chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	chk_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0C |=> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	chk_read_direct: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
		|=> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h00_0000)
		else $error("direct register read wrong");
	cov_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
	cov_unmapped: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rresp == 2'h2);
	cov_lit: cover property (@(posedge aclk) led_out != '0);
endmodule // plfe_top_monitor

bind plfe_top plfe_top_monitor #(.NUM_LEDS(NUM_LEDS)) chk_u (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.led_out(led_out)
);

// >>> bench/plfe_led_partner.sv
// Purpose: LED row seen from outside, counting how often each LED changes
// Assumes: led_out is registered on aclk
// Notes: clr restarts the counts so a window can be measured
`timescale 1ns/100ps
module plfe_led_partner #(
	parameter int NUM_LEDS = 4
) (
	input wire logic aclk, // core clock
	input wire logic clr, // restart counts
	input wire logic [NUM_LEDS-1:0] led_out, // LED pins, high lights
	output logic [NUM_LEDS-1:0][15:0] toggles // changes per LED
);
	logic [NUM_LEDS-1:0] last;
	always_ff @(posedge aclk) begin
		last <= led_out;
		for (int i = 0; i < NUM_LEDS; i++) begin
			if (clr) begin
				toggles[i] <= 16'h0000;
			end else if (led_out[i] != last[i]) begin
				toggles[i] <= toggles[i] + 16'h0001;
			end
		end
	end
endmodule // plfe_led_partner

// >>> bench/plfe_top_tb.sv
// Purpose: self-checking bench of the LED engine over AXI4-Lite
// Assumes: TICK_CYCLES of 4, so rate 0 gives fast halves of 100 and slow of 400 clocks
// Notes: blink counts allow one edge of slack, the shared phase runs free
`timescale 1ns/100ps
`include "plfe_cfg.svh"
module plfe_top_tb
	import plfe_pkg::*;
;
	logic aclk;
	logic aresetn;
	logic [7:0] s_axi_awaddr;
	logic s_axi_awvalid;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic s_axi_wvalid;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready;
	logic [7:0] s_axi_araddr;
	logic s_axi_arvalid;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready;
	logic [6:0] event_in;
	logic [3:0] led_out;
	logic clr;
	logic [3:0][15:0] toggles;
	logic [31:0] d;
	logic [1:0] r;
	logic [3:0] seen;
	int n_errors;
	int cmp_count;

	plfe_top #(.TICK_CYCLES(4)) dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.event_in(event_in), .led_out(led_out)
	);
	plfe_led_partner partner_u (.aclk(aclk), .clr(clr), .led_out(led_out), .toggles(toggles));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wrap_up();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, got, exp);
		end
	endtask

	// master offers address and data together, bready up from the start
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
		end
		check(32'h0000_0000, 32'h0000_0001);
		wrap_up();
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		check(32'h0000_0000, 32'h0000_0001);
		wrap_up();
	endtask

	task automatic watch(input int n);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (n) @(posedge aclk);
	endtask

	// walk positions one at a time; inv expects three lit instead of one
	task automatic walk_check(input int lit);
		seen = 4'h0;
		repeat (80) begin
			repeat (10) @(posedge aclk);
			seen = seen | (lit == 1 ? led_out : ~led_out);
			check($countones(led_out), lit);
		end
		check(seen, 4'hF);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		n_errors = 0;
		cmp_count = 0;
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		event_in = 7'h00;
		clr = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`PLFE_ADDR_DIRECT);
		check(d, `PLFE_RST_DIRECT);
		rd(`PLFE_ADDR_COMPLEX);
		check(d, `PLFE_RST_COMPLEX);
		rd(8'h0C);
		check(r, PLFE_RESP_SLVERR);
		wr(`PLFE_ADDR_STATUS, 32'h0000_000F);
		check(r, PLFE_RESP_SLVERR);
		// external mode must ignore a running complex function
		wr(`PLFE_ADDR_COMPLEX, 32'h0000_0200);
		wr(`PLFE_ADDR_DIRECT, 32'h0000_0005);
		repeat (2) @(posedge aclk);
		check(led_out, 4'h5);
		watch(250);
		check(led_out, 4'h5);
		wr(`PLFE_ADDR_DIRECT, 32'h0000_000A);
		repeat (2) @(posedge aclk);
		check(led_out, 4'hA);
		wr(`PLFE_ADDR_DIRECT, 32'h0000_00F0);
		walk_check(1);
		wr(`PLFE_ADDR_COMPLEX, 32'h0000_0600);
		walk_check(1);
		wr(`PLFE_ADDR_COMPLEX, 32'h0000_0400);
		walk_check(3);
		wr(`PLFE_ADDR_COMPLEX, 32'h0000_0700);
		watch(800);
		check(led_out[0] ^ led_out[1], 1'b1);
		check({led_out[0], led_out[1]}, {led_out[2], led_out[3]});
		check(toggles[0] inside {[7:9]}, 1'b1);
		// fast rate one doubles the half period to 200 clocks
		wr(`PLFE_ADDR_COMPLEX, 32'h0000_0701);
		watch(800);
		check(toggles[0] inside {[3:5]}, 1'b1);
		// direct functions: const ev0 and fast ev1 on LED0, slow ev1 on LED1
		wr(`PLFE_ADDR_COMPLEX, 32'h0000_0000);
		wr(`PLFE_ADDR_LEDCFG_BASE, 32'h0000_1020);
		wr(`PLFE_ADDR_LEDCFG_BASE + 8'h04, 32'h0000_0200);
		wr(`PLFE_ADDR_LEDCFG_BASE + 8'h08, 32'h0000_1003);
		rd(`PLFE_ADDR_LEDCFG_BASE + 8'h08);
		check(d, 32'h0000_1003);
		event_in <= 7'h01;
		repeat (3) @(posedge aclk);
		check(led_out, 4'h5);
		event_in <= 7'h03;
		watch(800);
		check(toggles[0] inside {[7:9]}, 1'b1);
		check(toggles[1] inside {[1:3]}, 1'b1);
		check(toggles[3], 16'h0000);
		// pulse on a lit LED: one dark gap, a rise during it is ignored
		event_in <= 7'h01;
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		event_in <= 7'h05;
		repeat (30) @(posedge aclk);
		event_in <= 7'h01;
		repeat (120) @(posedge aclk);
		event_in <= 7'h05;
		repeat (250) @(posedge aclk);
		check(toggles[2], 16'h0002);
		check(led_out[2], 1'b1);
		event_in <= 7'h01;
		watch(10);
		event_in <= 7'h05;
		repeat (150) @(posedge aclk);
		check(led_out[2], 1'b0);
		repeat (150) @(posedge aclk);
		check(toggles[2], 16'h0002);
		rd(`PLFE_ADDR_STATUS);
		check(d, 32'h0000_0005);
		wrap_up();
	end
endmodule // plfe_top_tb
